// ---- crt_consts.vh ----
/*
 constants of the raster timing controller: register indices, field
 positions, mode codes and the two mask-stored screen formats.
 assumes inclusion by bare name from every design file that needs it.
*/
// Contract
// R1: refresh address output is 14 bits wide, reaching 16K locations.
// R2: scan-line address output is 5 bits, up to 32 lines per row.
// R3: cursor output is high exactly while the cursor is displayed.
// R4: writes are accepted only while chip select is low.
// R5: select 0 writes the index register, select 1 the indexed data register.
// R6: processor writes the index first, then the data, chip select low both times.
// R7: writes need the write line low; data lines are never driven.
// R8: data and register select are captured on enable's falling edge.
// R9: raster counters advance once per character clock.
// R10: format select low picks format 0, high picks format 1.
// R11: reset loads start address, homes counters, drives other outputs low.
// R12: reset leaves every stored register unchanged.
// R13: display resumes at once when reset is released.
// R14: index register is 5 bits; writable registers are write only.
// R15: horizontal total sets the full line period in character times.
// R16: horizontal enable lasts displayed count; sync starts at sync position.
// R17: horizontal sync width is the low four bits, never zero.
// R18: vertical sync width is the high four bits, zero meaning 16.
// R19: frame is total rows plus adjust scan lines.
// R20: vertical enable covers displayed rows from the top.
// R21: vertical sync starts at stored row position.
// R22: interlace field picks normal, interlaced sync, or sync and video.
// R23: start address is high six and low eight bits; counter starts there.
// R24: cursor address is high six and low eight bits.
// R25: display enable is horizontal enable and vertical enable.
// R26: indices 12 to 15 select start high, start low, cursor high, cursor low.
// R27: cursor when address matches and line in range; blink per mode.
`ifndef CRT_CONSTS_VH
`define CRT_CONSTS_VH
`define CRT_IDX_START_HI 5'h0c
`define CRT_IDX_START_LO 5'h0d
`define CRT_IDX_CURS_HI 5'h0e
`define CRT_IDX_CURS_LO 5'h0f
`define CRT_IDX_W 5
`define CRT_ADDR_W 14
`define CRT_ROW_W 5
`define CRT_HSW_LSB 0
`define CRT_VSW_LSB 4
`define CRT_ILACE_NORMAL 2'h0
`define CRT_ILACE_SYNC 2'h1
`define CRT_ILACE_VIDEO 2'h3
`define CRT_CMODE_STEADY 2'h0
`define CRT_CMODE_OFF 2'h1
`define CRT_CMODE_FAST 2'h2
`define CRT_CMODE_SLOW 2'h3
`define CRT_BLINK_FAST_BIT 3
`define CRT_BLINK_SLOW_BIT 4
// format 0: 80x25 text, 8 line rows
`define CRT_F0_HTOTAL 8'h63
`define CRT_F0_HDISP 8'h50
`define CRT_F0_HSPOS 8'h52
`define CRT_F0_SYNCW 8'h2c
`define CRT_F0_VTOTAL 7'h1f
`define CRT_F0_VADJ 5'h06
`define CRT_F0_VDISP 7'h19
`define CRT_F0_VSPOS 7'h1c
`define CRT_F0_ILACE 2'h0
`define CRT_F0_MAXLINE 5'h07
`define CRT_F0_CSTART 5'h06
`define CRT_F0_CEND 5'h07
`define CRT_F0_CMODE 2'h3
// format 1: 64x16 text, 12 line rows
`define CRT_F1_HTOTAL 8'h4f
`define CRT_F1_HDISP 8'h40
`define CRT_F1_HSPOS 8'h44
`define CRT_F1_SYNCW 8'h46
`define CRT_F1_VTOTAL 7'h19
`define CRT_F1_VADJ 5'h02
`define CRT_F1_VDISP 7'h10
`define CRT_F1_VSPOS 7'h16
`define CRT_F1_ILACE 2'h1
`define CRT_F1_MAXLINE 5'h0b
`define CRT_F1_CSTART 5'h00
`define CRT_F1_CEND 5'h0b
`define CRT_F1_CMODE 2'h0
`endif

// ---- crt_format_rom.v ----
/*
 mask-stored screen format: two fixed parameter sets, one picked by a
 level. outputs registered; assumes the select is already synchronised.
*/
`include "crt_consts.vh"
module crt_format_rom (
	input wire ref_clk,
	input wire sel,
	output reg [7:0] horiz_total,
	output reg [7:0] horiz_displayed,
	output reg [7:0] hsync_position,
	output reg [7:0] sync_widths,
	output reg [6:0] vert_total,
	output reg [4:0] vert_total_adjust,
	output reg [6:0] vert_displayed,
	output reg [6:0] vsync_position,
	output reg [1:0] interlace_select,
	output reg [4:0] max_line,
	output reg [4:0] cursor_start,
	output reg [4:0] cursor_end,
	output reg [1:0] cursor_mode
);
	// no reset: stored formats are untouched by raster reset
	always @(posedge ref_clk) begin // see R12
		if (sel) begin // see R10
			horiz_total <= `CRT_F1_HTOTAL;
			horiz_displayed <= `CRT_F1_HDISP;
			hsync_position <= `CRT_F1_HSPOS;
			sync_widths <= `CRT_F1_SYNCW;
			vert_total <= `CRT_F1_VTOTAL;
			vert_total_adjust <= `CRT_F1_VADJ;
			vert_displayed <= `CRT_F1_VDISP;
			vsync_position <= `CRT_F1_VSPOS;
			interlace_select <= `CRT_F1_ILACE;
			max_line <= `CRT_F1_MAXLINE;
			cursor_start <= `CRT_F1_CSTART;
			cursor_end <= `CRT_F1_CEND;
			cursor_mode <= `CRT_F1_CMODE;
		end else begin
			horiz_total <= `CRT_F0_HTOTAL;
			horiz_displayed <= `CRT_F0_HDISP;
			hsync_position <= `CRT_F0_HSPOS;
			sync_widths <= `CRT_F0_SYNCW;
			vert_total <= `CRT_F0_VTOTAL;
			vert_total_adjust <= `CRT_F0_VADJ;
			vert_displayed <= `CRT_F0_VDISP;
			vsync_position <= `CRT_F0_VSPOS;
			interlace_select <= `CRT_F0_ILACE;
			max_line <= `CRT_F0_MAXLINE;
			cursor_start <= `CRT_F0_CSTART;
			cursor_end <= `CRT_F0_CEND;
			cursor_mode <= `CRT_F0_CMODE;
		end
	end
endmodule

// ---- crt_bus_write.v ----
/*
 processor write port: synchronises the strobe pins, catches the falling
 edge of enable and writes index or indexed data register. write only.
 assumes the bus pins are asynchronous to ref_clk.
*/
`include "crt_consts.vh"
module crt_bus_write (
	input wire ref_clk,
	input wire cs_n,
	input wire reg_sel,
	input wire wr_n,
	input wire bus_en,
	input wire [7:0] data_in,
	output reg [`CRT_ADDR_W-1:0] start_addr,
	output reg [`CRT_ADDR_W-1:0] cursor_addr
);
	reg [3:0] sync1;
	reg [3:0] sync2;
	reg [7:0] data1;
	reg [7:0] data2;
	reg en_prev;
	reg [`CRT_IDX_W-1:0] register_index_select;
	wire en_fall;
	wire take;

	// two-stage synchronisers; register contents deliberately have no reset
	always @(posedge ref_clk) begin
		sync1 <= {bus_en, reg_sel, wr_n, cs_n};
		sync2 <= sync1;
		data1 <= data_in; // data lines gated by enable below, never driven
		data2 <= data1;
		en_prev <= sync2[3];
	end

	assign en_fall = en_prev & ~sync2[3]; // see R8
	assign take = en_fall & ~sync2[0] & ~sync2[1]; // see R4 see R7

	// index or data write; data setup far exceeds sync lag of the strobe
	always @(posedge ref_clk) begin // see R12
		if (take) begin
			if (!sync2[2]) begin
				register_index_select <= data2[`CRT_IDX_W-1:0]; // see R5 see R14
			end else begin
				case (register_index_select) // see R26
				`CRT_IDX_START_HI: start_addr[13:8] <= data2[5:0]; // see R23
				`CRT_IDX_START_LO: start_addr[7:0] <= data2;
				`CRT_IDX_CURS_HI: cursor_addr[13:8] <= data2[5:0]; // see R24
				`CRT_IDX_CURS_LO: cursor_addr[7:0] <= data2;
				default: ;
				endcase
			end
		end
	end
endmodule

// ---- crt_raster_timing.v ----
/*
 raster timing controller top: horizontal, scan-line, vertical and linear
 address counters, sync and enable flags, cursor and interlace handling.
 assumes ref_clk is the character-rate clock; nrst is a synchronous
 system reset, raster_reset_n an asynchronous pin.
*/
`include "crt_consts.vh"
module crt_raster_timing (
	input wire ref_clk,
	input wire nrst,
	input wire raster_reset_n,
	input wire format_select,
	input wire cs_n,
	input wire reg_sel,
	input wire wr_n,
	input wire bus_en,
	input wire [7:0] data_in,
	output reg [`CRT_ADDR_W-1:0] refresh_addr,
	output reg [`CRT_ROW_W-1:0] scanline_addr,
	output reg hsync,
	output reg vsync,
	output reg display_en,
	output reg cursor
);
	localparam ST_ROWS = 2'b01;
	localparam ST_ADJ = 2'b10;

	wire [7:0] horiz_total;
	wire [7:0] horiz_displayed;
	wire [7:0] hsync_position;
	wire [7:0] sync_widths;
	wire [6:0] vert_total;
	wire [4:0] vert_total_adjust;
	wire [6:0] vert_displayed;
	wire [6:0] vsync_position;
	wire [1:0] interlace_select;
	wire [4:0] max_line;
	wire [4:0] cursor_start;
	wire [4:0] cursor_end;
	wire [1:0] cursor_mode;
	wire [`CRT_ADDR_W-1:0] start_addr;
	wire [`CRT_ADDR_W-1:0] cursor_addr;

	reg [1:0] pin_sync;
	reg [1:0] res_sync;
	reg [7:0] hcount;
	reg [3:0] hs_count;
	reg [4:0] line;
	reg [6:0] row;
	reg [4:0] adj_count;
	reg [4:0] vs_count;
	reg [1:0] vstate;
	reg [`CRT_ADDR_W-1:0] row_base;
	reg [`CRT_ADDR_W-1:0] addr;
	reg h_de;
	reg v_de;
	reg field;
	reg [4:0] frame_count;
	reg next_v_de;
	reg [4:0] next_vs_count;
	wire in_reset;
	wire line_end;
	wire row_end;
	wire frame_end;
	wire [4:0] vsync_width;
	wire [4:0] eff_line;
	wire shift_vs;
	wire half_line;
	reg blink_on;
	reg vs_line;

	// either interlace mode toggles the field every frame
	function is_interlaced;
		input [1:0] mode;
		begin
			is_interlaced = (mode != `CRT_ILACE_NORMAL);
		end
	endfunction

	// sync and video mode steps lines by two with the field as lowest bit
	function is_video;
		input [1:0] mode;
		begin
			is_video = (mode == `CRT_ILACE_VIDEO);
		end
	endfunction

	crt_format_rom u_rom (
		.ref_clk(ref_clk),
		.sel(pin_sync[1]),
		.horiz_total(horiz_total),
		.horiz_displayed(horiz_displayed),
		.hsync_position(hsync_position),
		.sync_widths(sync_widths),
		.vert_total(vert_total),
		.vert_total_adjust(vert_total_adjust),
		.vert_displayed(vert_displayed),
		.vsync_position(vsync_position),
		.interlace_select(interlace_select),
		.max_line(max_line),
		.cursor_start(cursor_start),
		.cursor_end(cursor_end),
		.cursor_mode(cursor_mode)
	);

	crt_bus_write u_bus (
		.ref_clk(ref_clk),
		.cs_n(cs_n),
		.reg_sel(reg_sel),
		.wr_n(wr_n),
		.bus_en(bus_en),
		.data_in(data_in),
		.start_addr(start_addr),
		.cursor_addr(cursor_addr)
	);

	// format pin and raster reset pin enter through two flip-flops
	always @(posedge ref_clk) begin
		if (!nrst) begin
			pin_sync <= 2'h0;
			res_sync <= 2'h0;
		end else begin
			pin_sync <= {pin_sync[0], format_select}; // see R10
			res_sync <= {res_sync[0], raster_reset_n};
		end
	end

	// either reset holds the raster home until two clocks after release, while res_sync refills
	assign in_reset = ~nrst | ~res_sync[1]; // see R11 see R13

	// zero-based compare: a total of n gives n+1 characters per line
	assign line_end = (hcount == horiz_total); // see R15
	// interlace sync and video steps lines by two, so ends one earlier
	assign row_end = is_video(interlace_select) ?
		(line >= max_line - 5'h01) : (line == max_line);
	// an adjust of n gives exactly n extra lines, adj_count running 0..n-1
	assign frame_end = (vstate == ST_ADJ) ? (adj_count == vert_total_adjust - 5'h01) :
		(row_end && row == vert_total && vert_total_adjust == 5'h00); // see R19
	assign vsync_width = (sync_widths[7:4] == 4'h0) ? 5'h10 :
		{1'b0, sync_widths[7:4]}; // see R18
	assign eff_line = is_video(interlace_select) ? (line | {4'h0, field}) : line;
	// odd fields of the interlace modes move vsync by half a line
	assign shift_vs = field & is_interlaced(interlace_select); // see R22
	assign half_line = (hcount == {1'b0, horiz_total[7:1]});

	// blink rates from the frame counter; off mode keeps the cursor dark
	always @* begin
		case (cursor_mode)
		`CRT_CMODE_STEADY: blink_on = 1'b1;
		`CRT_CMODE_FAST: blink_on = frame_count[`CRT_BLINK_FAST_BIT]; // see R27
		`CRT_CMODE_SLOW: blink_on = frame_count[`CRT_BLINK_SLOW_BIT];
		default: blink_on = 1'b0;
		endcase
	end

	// horizontal counter, enable and sync
	always @(posedge ref_clk) begin
		if (in_reset) begin
			hcount <= 8'h00;
			h_de <= 1'b1;
			hs_count <= 4'h0;
			hsync <= 1'b0; // see R11
		end else begin
			hcount <= line_end ? 8'h00 : hcount + 8'h01; // see R9
			if (line_end) begin
				h_de <= 1'b1;
			end else if (hcount + 8'h01 == horiz_displayed) begin
				h_de <= 1'b0; // see R16
			end
			// width zero is illegal and would give no pulse at all
			if (hcount == hsync_position && sync_widths[3:0] != 4'h0) begin
				hsync <= 1'b1; // see R16
				hs_count <= sync_widths[3:0] - 4'h1; // see R17
			end else if (hs_count != 4'h0) begin
				hs_count <= hs_count - 4'h1;
			end else begin
				hsync <= 1'b0;
			end
		end
	end

	// vertical enable and sync width for the next line
	always @* begin
		next_v_de = v_de;
		next_vs_count = vs_count;
		if (frame_end) begin
			next_v_de = (vert_displayed != 7'h00);
		end else if (row_end && row + 7'h01 == vert_displayed) begin
			next_v_de = 1'b0; // see R20
		end
		if (row_end && vstate == ST_ROWS && row + 7'h01 == vsync_position) begin
			next_vs_count = vsync_width; // see R21
		end else if (vs_count != 5'h00) begin
			next_vs_count = vs_count - 5'h01;
		end
	end

	// scan line, row, adjust, field and frame counters at line end
	always @(posedge ref_clk) begin
		if (in_reset) begin
			line <= 5'h00;
			row <= 7'h00;
			adj_count <= 5'h00;
			vstate <= ST_ROWS;
			v_de <= 1'b1;
			vs_count <= 5'h00;
			vs_line <= 1'b0;
			field <= 1'b0;
			frame_count <= 5'h00;
		end else if (line_end) begin
			v_de <= next_v_de;
			vs_count <= next_vs_count;
			vs_line <= (next_vs_count != 5'h00); // line-aligned sync flag
			if (frame_end) begin
				line <= 5'h00;
				row <= 7'h00;
				adj_count <= 5'h00;
				vstate <= ST_ROWS;
				// field toggles only in the interlaced modes
				field <= is_interlaced(interlace_select) ? ~field : 1'b0; // see R22
				frame_count <= frame_count + 5'h01;
			end else begin
				case (vstate)
				ST_ROWS: begin
					if (row_end) begin
						line <= 5'h00;
						if (row == vert_total) begin
							vstate <= ST_ADJ; // see R19
						end else begin
							row <= row + 7'h01;
						end
					end else if (is_video(interlace_select)) begin
						line <= line + 5'h02; // see R22
					end else begin
						line <= line + 5'h01;
					end
				end
				ST_ADJ: begin
					adj_count <= adj_count + 5'h01;
					line <= line + 5'h01;
				end
				default: vstate <= ST_ROWS;
				endcase
			end
		end
	end

	// vsync output: at line end, or half a line late in odd interlaced fields
	always @(posedge ref_clk) begin
		if (in_reset) begin
			vsync <= 1'b0; // see R11
		end else if (shift_vs) begin
			if (half_line) begin
				vsync <= vs_line; // see R22
			end
		end else if (line_end) begin
			vsync <= (next_vs_count != 5'h00); // see R21
		end
	end

	// linear address counter: row base advances by displayed count per row
	always @(posedge ref_clk) begin
		if (in_reset) begin
			row_base <= start_addr; // see R23
			addr <= start_addr;
		end else if (line_end) begin
			if (frame_end) begin
				row_base <= start_addr;
				addr <= start_addr;
			end else if (row_end && vstate == ST_ROWS) begin
				row_base <= row_base + {6'h00, horiz_displayed};
				addr <= row_base + {6'h00, horiz_displayed};
			end else begin
				addr <= row_base;
			end
		end else begin
			addr <= addr + 14'h0001; // wraps through the 16K block
		end
	end

	// registered outputs
	always @(posedge ref_clk) begin
		if (in_reset) begin
			refresh_addr <= start_addr; // see R11 see R1
			scanline_addr <= 5'h00;
			display_en <= 1'b0;
			cursor <= 1'b0;
		end else begin
			refresh_addr <= addr; // see R1
			scanline_addr <= eff_line; // see R2
			display_en <= h_de & v_de; // see R25
			cursor <= h_de & v_de & (addr == cursor_addr) & blink_on &
				(eff_line >= cursor_start) & (eff_line <= cursor_end); // see R3 see R27 see R24
		end
	end
endmodule

// ---- crt_raster_timing_sva.sv ----
/*
 checker for the raster timing top: sync widths, line period, enables, reset.
 assumes the two built-in formats and a 14-bit refresh address.
*/
module crt_raster_timing_sva (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic raster_reset_n,
	input wire logic [13:0] refresh_addr,
	input wire logic [4:0] scanline_addr,
	input wire logic hsync,
	input wire logic vsync,
	input wire logic display_en,
	input wire logic cursor
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	logic [3:0] rq;
	logic [9:0] hhi, hlo, dhi, vhi;
	logic hv;
	wire quiet = &{rq, raster_reset_n};
	// run lengths; the raster reset pin is async, so keep a few samples of it
	always @(posedge ref_clk) begin
		rq <= {rq[2:0], raster_reset_n};
		hhi <= hsync ? hhi + 10'h001 : 10'h000;
		hlo <= hsync ? 10'h000 : hlo + 10'h001;
		dhi <= display_en ? dhi + 10'h001 : 10'h000;
		vhi <= vsync ? vhi + 10'h001 : 10'h000;
		hv <= nrst && raster_reset_n && (hv || (hhi != 10'h000 && !hsync));
	end
	sequence s_held_reset;
		!nrst ##1 !nrst;
	endsequence
	a_hsync_width: assert property ($fell(hsync) && quiet |-> hhi == 10'h00c || hhi == 10'h006)
		else $error("hsync width wrong");
	a_line_period: assert property ($rose(hsync) && hv |-> hlo == 10'h058 || hlo == 10'h04a)
		else $error("line period wrong");
	a_de_width: assert property ($fell(display_en) && quiet |-> dhi == 10'h050 || dhi == 10'h040)
		else $error("display width wrong");
	a_vsync_width: assert property ($fell(vsync) && quiet |-> vhi == 10'h0c8 || vhi == 10'h140)
		else $error("vsync width wrong");
	a_de_blank_hs: assert property (display_en |-> !hsync)
		else $error("hsync inside display");
	a_de_blank_vs: assert property (vsync |-> !display_en)
		else $error("display inside vsync");
	a_addr_step: assert property (display_en && $past(display_en) && quiet |-> refresh_addr == $past(refresh_addr) + 14'h0001)
		else $error("refresh address did not step");
	a_scan_max: assert property (scanline_addr <= 5'h0b)
		else $error("scan line out of range");
	a_cursor_in_de: assert property (cursor |-> display_en)
		else $error("cursor outside display");
	a_reset_quiet: assert property (disable iff (1'b0) s_held_reset |-> !(hsync | vsync | display_en | cursor) && scanline_addr == 5'h00)
		else $error("outputs active in reset");
	a_resume_now: assert property ($rose(nrst) && quiet |-> ##[1:3] display_en)
		else $error("display late after reset");
endmodule
bind crt_raster_timing crt_raster_timing_sva chk (.ref_clk(ref_clk), .nrst(nrst), .raster_reset_n(raster_reset_n),
	.refresh_addr(refresh_addr), .scanline_addr(scanline_addr), .hsync(hsync), .vsync(vsync),
	.display_en(display_en), .cursor(cursor));

// ---- crt_cpu_model.sv ----
/*
 processor side of the write port: one write per call, strobes at falling clock.
 assumes bus pins are sampled by the block through synchronisers.
*/
module crt_cpu_model (
	input wire logic ref_clk,
	output logic cs_n,
	output logic reg_sel,
	output logic wr_n,
	output logic bus_en,
	output logic [7:0] data_in
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		cs_n = 1'b1;
		reg_sel = 1'b0;
		wr_n = 1'b1;
		bus_en = 1'b0;
		data_in = 8'h00;
	end
	// select and address settle before enable and hold past its fall
	task wr(input logic rs, input logic [7:0] d, input logic sel, input logic wrt);
		@(negedge ref_clk);
		cs_n = ~sel;
		wr_n = ~wrt;
		reg_sel = rs;
		data_in = d;
		repeat (6) @(negedge ref_clk);
		bus_en = 1'b1;
		repeat (6) @(negedge ref_clk);
		bus_en = 1'b0;
		repeat (6) @(negedge ref_clk);
		cs_n = 1'b1;
		wr_n = 1'b1;
		data_in = ~d; // stale data must not look valid
	endtask
endmodule

// ---- testbench.sv ----
/*
 testbench for the raster timing top: writes, raster reset, line, frame, cursor.
 assumes the cpu model drives the bus and ref_clk runs at 200 MHz.
*/
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic raster_reset_n = 1'b0; // raster held home until start address is written
	logic format_select = 1'b0;
	logic cs_n, reg_sel, wr_n, bus_en, hsync, vsync, display_en, cursor;
	logic [7:0] data_in;
	logic [13:0] refresh_addr;
	logic [4:0] scanline_addr;
	int err_total = 0;
	int num_checks = 0;
	always #2.5 ref_clk = ~ref_clk;
	crt_cpu_model cpu (.ref_clk(ref_clk), .cs_n(cs_n), .reg_sel(reg_sel), .wr_n(wr_n), .bus_en(bus_en),
		.data_in(data_in));
	crt_raster_timing dut (.ref_clk(ref_clk), .nrst(nrst), .raster_reset_n(raster_reset_n),
		.format_select(format_select), .cs_n(cs_n), .reg_sel(reg_sel), .wr_n(wr_n), .bus_en(bus_en),
		.data_in(data_in), .refresh_addr(refresh_addr), .scanline_addr(scanline_addr), .hsync(hsync),
		.vsync(vsync), .display_en(display_en), .cursor(cursor));
	task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t %s got %h want %h", $time, what, got, exp);
		end
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	function logic pick(input int sel);
		return sel == 0 ? hsync : sel == 1 ? vsync : display_en;
	endfunction
	// bounded run length of one level; a stuck output ends the run
	task run_len(input int sel, input logic v, output logic [15:0] n);
		n = 16'h0000;
		while (pick(sel) === v) begin
			@(negedge ref_clk);
			n++;
			if (n > 16'h7530) begin
				err_total++;
				$display("BAD t=%0t output stuck", $time);
				stop_test();
			end
		end
	endtask
	// format changes only under raster reset, so no line mixes two formats
	task rreset(input logic fmt);
		logic [15:0] n;
		@(negedge ref_clk);
		raster_reset_n = 1'b0;
		format_select = fmt;
		repeat (6) @(negedge ref_clk);
		chk({2'b00, refresh_addr}, 16'h1234, "reset address");
		chk({11'h000, scanline_addr}, 16'h0000, "reset scan line");
		chk({12'h000, hsync, vsync, display_en, cursor}, 16'h0000, "reset outputs");
		raster_reset_n = 1'b1;
		run_len(2, 1'b0, n);
		chk({15'h0000, n < 16'h0008}, 16'h0001, "restart delay");
	endtask
	task t_regs;
		cpu.wr(1'b0, 8'h0c, 1'b1, 1'b1);
		cpu.wr(1'b1, 8'h12, 1'b1, 1'b1);
		cpu.wr(1'b0, 8'h0d, 1'b1, 1'b1);
		cpu.wr(1'b1, 8'h34, 1'b1, 1'b1);
		cpu.wr(1'b0, 8'h0e, 1'b1, 1'b1);
		cpu.wr(1'b1, 8'h12, 1'b1, 1'b1);
		cpu.wr(1'b0, 8'h0f, 1'b1, 1'b1);
		cpu.wr(1'b1, 8'h39, 1'b1, 1'b1);
		rreset(1'b0);
		cpu.wr(1'b0, 8'h0d, 1'b1, 1'b1);
		cpu.wr(1'b1, 8'h00, 1'b0, 1'b1);
		cpu.wr(1'b1, 8'h00, 1'b1, 1'b0);
		cpu.wr(1'b0, 8'h05, 1'b1, 1'b1);
		cpu.wr(1'b1, 8'h00, 1'b1, 1'b1);
		@(negedge ref_clk);
		nrst = 1'b0;
		repeat (3) @(negedge ref_clk);
		chk({2'b00, refresh_addr}, 16'h1234, "start kept");
		nrst = 1'b1;
		$display("register test done");
	endtask
	task t_line(input logic [15:0] per, input logic [15:0] hw, input logic [15:0] de);
		logic [15:0] n, h, l;
		run_len(2, 1'b0, n);
		run_len(2, 1'b1, n);
		chk(n, de, "display width");
		run_len(0, 1'b0, n);
		run_len(0, 1'b1, h);
		run_len(0, 1'b0, l);
		chk(h, hw, "hsync width");
		chk(h + l, per, "line period");
		$display("line test done");
	endtask
	task t_frame;
		logic [15:0] n, w;
		rreset(1'b0);
		run_len(1, 1'b0, n);
		chk((n + 16'h0032) / 16'h0064, 16'h00e0, "vsync line");
		run_len(1, 1'b1, w);
		run_len(1, 1'b0, n);
		chk(w, 16'h00c8, "vsync width");
		chk(w + n, 16'h6658, "frame period");
		$display("frame test done");
	endtask
	// steady full-height cursor of the second format covers one character
	task t_cursor;
		logic [15:0] n;
		rreset(1'b1);
		n = 16'h0000;
		repeat (1200) begin
			@(negedge ref_clk);
			n += cursor;
		end
		chk(n, 16'h000c, "cursor cycles");
		t_line(16'h0050, 16'h0006, 16'h0040);
		$display("cursor test done");
	endtask
	initial begin
		repeat (8) @(negedge ref_clk);
		chk({12'h000, hsync, vsync, display_en, cursor}, 16'h0000, "outputs in reset");
		nrst = 1'b1;
		t_regs();
		t_line(16'h0064, 16'h000c, 16'h0050);
		t_frame();
		t_cursor();
		stop_test();
	end
endmodule
